/* File: inc/fps_map.svh */
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ----------------------------------------
// command opcodes
// ----------------------------------------
`define FPS_OPC_WR_ENABLE      8'h06
`define FPS_OPC_PAGE_PROG      8'h02
`define FPS_OPC_PAGE_PROG_4B   8'h12
`define FPS_OPC_QUAD_PROG      8'h32
`define FPS_OPC_QUAD_PROG_4B   8'h34
`define FPS_OPC_PARAM_ERASE    8'h20
`define FPS_OPC_PARAM_ERASE_4B 8'h21

// ----------------------------------------
// geometry
// ----------------------------------------
`define FPS_PAGE_LAST_SMALL    9'h0ff
`define FPS_PAGE_LAST_LARGE    9'h1ff
`define FPS_PSECT_BITS         12
`define FPS_PREGION_BITS       15
`define FPS_ADDR_LAST_3B       2'h2
`define FPS_ADDR_LAST_4B       2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define FPS_RST_ADDR           32'h0000_0000
`define FPS_RST_PIN_SAMPLE     6'h10

`endif

/* File: inc/fps_pkg.sv */
package fps_pkg;

	typedef enum logic [2:0] {
		L_IDLE  = 3'h0,
		L_ADDR  = 3'h1,
		L_DATA  = 3'h2,
		L_ARMED = 3'h3,
		L_SKIP  = 3'h4
	} fps_link_st_t;

	typedef enum logic [1:0] {
		E_IDLE = 2'h0,
		E_PROG = 2'h1,
		E_WAIT = 2'h2
	} fps_eng_st_t;

	typedef struct packed {
		logic page_size_select;
		logic address_length_select;
		logic alt_address_length_bit;
		logic uniform_sector_select;
		logic quad_enable;
		logic four_lane_command_mode;
		logic param_top;
	} fps_cfg_t;

	typedef struct packed {
		logic        bp_en;
		logic [31:0] bp_lo;
		logic [31:0] bp_hi;
		logic [7:0]  per_sector_protection;
	} fps_prot_t;

	typedef struct packed {
		logic write_in_progress;
		logic write_enable_latch;
		logic program_fail_bit;
		logic erase_fail_bit;
	} fps_status_t;

	typedef struct packed {
		logic        wr;
		logic        erase;
		logic        commit;
		logic        ecc_dis;
		logic [31:0] addr;
		logic [7:0]  data;
	} fps_arr_t;

endpackage

/* File: hdl/fps_sync.sv */
`timescale 1ns/1ps
module fps_sync #(
	parameter int               WIDTH   = 6,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// data
	input  wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0]      q_o
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule

/* File: hdl/fps_page_buf.sv */
`timescale 1ns/1ps
module fps_page_buf #(
	parameter int DEPTH = 512,
	parameter int AW    = 9,
	parameter int DW    = 8
) (
	// clock
	input  wire logic          clk_i,
	// write side
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	// read side
	input  wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0]      rdata_o
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_o <= mem[raddr_i];
	end

endmodule

/* File: hdl/fps_top.sv */
// Overview of operation
// - page is 256 or 512 bytes, chosen by page_size_select
// - pages align to their size; one byte to one page per operation
// - single bytes allowed; reprogramming a 16-byte unit disables its ECC
// - page program needs write_enable_latch set by a prior enable command
// - 02h takes 3 or 4 address bytes per address_length_select; 12h four
// - data past the page end wraps to byte zero of the same page
// - short loads program in sequence, other page bytes untouched
// - write_in_progress shows progress; program_fail_bit flags failure
// - four-lane mode moves opcode, address and data on IO0 to IO3
// - four-line page program loads four data bits per clock
// - four-line page program needs quad_enable and the latch set
// - 32h address length per alt_address_length_bit; 34h four bytes
// - parameter sectors sit at bottom or top, or uniform only
// - parameter erase opcodes ignored with uniform_sector_select set
// - parameter erase sets the sector to ones; needs latch set
// - 20h takes 3 or 4 address bytes per address_length_select; 21h four
// - erase starts at chip select rise right after address, else dropped
// - write_in_progress is one for the erase and zero after it
// - protected erase target is refused and sets erase_fail_bit
// - erase outside 4 KB sectors is refused, error flag unchanged
// - four-lane mode shifts erase opcode and address four bits per clock
// - first program stores ECC per unit; a second one disables it
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_top #(
	parameter int ADDR_BITS = 23
) (
	// clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               reset_n_i,
	// serial link
	input  wire logic               sck_i,
	input  wire logic               cs_n_i,
	input  wire logic [3:0]         io_i,
	output logic [3:0]              io_o,
	output logic [3:0]              io_oe_o,
	// configuration and protection
	input  wire fps_pkg::fps_cfg_t  cfg_i,
	input  wire fps_pkg::fps_prot_t prot_i,
	input  wire logic               clr_err_i,
	// status
	output fps_pkg::fps_status_t    status_o,
	// array engine
	output fps_pkg::fps_arr_t       arr_o,
	input  wire logic               arr_unit_used_i,
	input  wire logic               arr_done_i,
	input  wire logic               arr_fail_i
);
	import fps_pkg::*;

	// ----------------------------------------
	// reset release and pin sampling
	// ----------------------------------------
	logic [1:0]   rst_sync_reg;
	logic         rst_n;
	logic [5:0]   pins_s;
	logic         sck_s;
	logic         cs_n_s;
	logic [3:0]   io_s;
	logic         sck_d_reg;
	logic         cs_n_d_reg;
	logic         sck_rise;
	logic         cs_rise;
	logic         sel;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	fps_sync #(
		.WIDTH   (6),
		.RST_VAL (`FPS_RST_PIN_SAMPLE)
	) u_sync (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n),
		.d_i     ({sck_i, cs_n_i, io_i}),
		.q_o     (pins_s)
	);
	assign sck_s  = pins_s[5];
	assign cs_n_s = pins_s[4];
	assign io_s   = pins_s[3:0];

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sck_d_reg  <= 1'b0;
			cs_n_d_reg <= 1'b1;
		end else begin
			sck_d_reg  <= sck_s;
			cs_n_d_reg <= cs_n_s;
		end
	end
	assign sck_rise = sck_s & ~sck_d_reg;
	assign cs_rise  = cs_n_s & ~cs_n_d_reg;
	assign sel      = ~cs_n_s;

	// these commands never answer on the IO lines
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			io_o    <= 4'h0;
			io_oe_o <= 4'h0;
		end else begin
			io_o    <= 4'h0;
			io_oe_o <= 4'h0;
		end
	end

	// ----------------------------------------
	// byte assembly
	// ----------------------------------------
	fps_link_st_t lst_reg;
	fps_eng_st_t  eng_reg;
	logic         op_quad_reg;
	logic         op_erase_reg;
	logic         op_write_enable_command_reg;
	logic [7:0]   sh_reg;
	logic [2:0]   bit_cnt_reg;
	logic         quad_lanes;
	logic         byte_ev;
	logic [7:0]   byte_new;

	assign quad_lanes = cfg_i.four_lane_command_mode
		| (lst_reg == L_DATA && op_quad_reg);
	assign byte_new = quad_lanes ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
	assign byte_ev  = sel & sck_rise & (bit_cnt_reg == (quad_lanes ? 3'h1 : 3'h7));

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg      <= 8'h00;
			bit_cnt_reg <= 3'h0;
		end else if (!sel) begin
			bit_cnt_reg <= 3'h0;
		end else if (sck_rise) begin
			sh_reg      <= byte_new;
			bit_cnt_reg <= byte_ev ? 3'h0 : 3'(bit_cnt_reg + 3'h1);
		end
	end

	// ----------------------------------------
	// opcode decode and launch checks
	// ----------------------------------------
	logic         dec_prog;
	logic         dec_erase;
	logic         dec_write_enable_command;
	logic         dec_quad;
	logic         dec_4b;
	logic         wip_reg;
	logic         wel_reg;
	logic         perr_reg;
	logic         eerr_reg;
	logic         acc_ok;
	logic [31:0]  addr_reg;
	logic [1:0]   addr_cnt_reg;
	logic [1:0]   addr_last_reg;
	logic [8:0]   wr_off_reg;
	logic         got_data_reg;
	logic [8:0]   pg_last;
	logic [ADDR_BITS-1:0] a_low;
	logic         in_param;
	logic         hit_prot;
	logic         at_open;
	logic         rej_op;
	logic         write_enable_command_done;
	logic         erase_end;
	logic         prog_end;
	logic         go_prog;
	logic         go_erase;
	logic         eng_done;
	logic         set_perr;
	logic         set_eerr;
	logic         wel_clr;

	always_comb begin
		dec_prog  = 1'b0;
		dec_erase = 1'b0;
		dec_write_enable_command  = 1'b0;
		dec_quad  = 1'b0;
		dec_4b    = 1'b1;
		unique case (byte_new)
			`FPS_OPC_WR_ENABLE: begin
				dec_write_enable_command = 1'b1;
			end
			`FPS_OPC_PAGE_PROG: begin
				dec_prog = 1'b1;
				dec_4b   = cfg_i.address_length_select;
			end
			`FPS_OPC_PAGE_PROG_4B: begin
				dec_prog = 1'b1;
			end
			`FPS_OPC_QUAD_PROG: begin
				dec_prog = 1'b1;
				dec_quad = 1'b1;
				dec_4b   = cfg_i.alt_address_length_bit;
			end
			`FPS_OPC_QUAD_PROG_4B: begin
				dec_prog = 1'b1;
				dec_quad = 1'b1;
			end
			`FPS_OPC_PARAM_ERASE: begin
				dec_erase = 1'b1;
				dec_4b    = cfg_i.address_length_select;
			end
			`FPS_OPC_PARAM_ERASE_4B: begin
				dec_erase = 1'b1;
			end
			default: begin
				dec_4b = 1'b1;
			end
		endcase
	end

	assign pg_last = cfg_i.page_size_select ? `FPS_PAGE_LAST_LARGE
		: `FPS_PAGE_LAST_SMALL;
	assign a_low = addr_reg[ADDR_BITS-1:0];
	// parameter sectors fill the lowest or highest 32 KB region
	assign in_param = !cfg_i.uniform_sector_select
		&& (cfg_i.param_top ? (&a_low[ADDR_BITS-1:`FPS_PREGION_BITS])
		: (a_low[ADDR_BITS-1:`FPS_PREGION_BITS] == '0));
	assign hit_prot = (prot_i.bp_en && addr_reg >= prot_i.bp_lo && addr_reg <= prot_i.bp_hi)
		|| (in_param && prot_i.per_sector_protection[
			a_low[`FPS_PREGION_BITS-1:`FPS_PSECT_BITS]]);

	assign acc_ok = !wip_reg && wel_reg
		&& (!dec_quad || cfg_i.quad_enable);
	assign at_open   = lst_reg == L_IDLE && byte_ev;
	assign rej_op    = at_open && (dec_prog || (dec_erase && !cfg_i.uniform_sector_select))
		&& !acc_ok;
	assign write_enable_command_done = cs_rise && lst_reg == L_ARMED && op_write_enable_command_reg && !wip_reg;
	// op_erase_reg outlives its frame, so a later enable frame must not re-arm it
	assign erase_end = cs_rise && lst_reg == L_ARMED && op_erase_reg && !op_write_enable_command_reg;
	assign prog_end  = cs_rise && lst_reg == L_DATA && got_data_reg;
	assign go_erase  = erase_end && in_param && !hit_prot;
	assign go_prog   = prog_end && !hit_prot;
	assign eng_done  = eng_reg == E_WAIT && arr_done_i;
	assign set_eerr  = (erase_end && in_param && hit_prot)
		|| (eng_done && arr_fail_i && op_erase_reg);
	assign set_perr  = (prog_end && hit_prot)
		|| (eng_done && arr_fail_i && !op_erase_reg);
	assign wel_clr   = rej_op || erase_end || prog_end || eng_done;

	// ----------------------------------------
	// link state machine
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			lst_reg       <= L_IDLE;
			op_quad_reg   <= 1'b0;
			op_erase_reg  <= 1'b0;
			op_write_enable_command_reg   <= 1'b0;
			addr_reg      <= `FPS_RST_ADDR;
			addr_cnt_reg  <= 2'h0;
			addr_last_reg <= `FPS_ADDR_LAST_3B;
			wr_off_reg    <= 9'h000;
			got_data_reg  <= 1'b0;
		end else if (!sel) begin
			lst_reg <= L_IDLE;
		end else if (sck_rise) begin
			unique case (lst_reg)
				L_IDLE: begin
					if (byte_ev) begin
						addr_cnt_reg  <= 2'h0;
						addr_last_reg <= dec_4b ? `FPS_ADDR_LAST_4B : `FPS_ADDR_LAST_3B;
						op_write_enable_command_reg   <= dec_write_enable_command;
						if (dec_write_enable_command) begin
							lst_reg <= L_ARMED;
						end else if ((dec_prog || dec_erase) && acc_ok
							&& !(dec_erase && cfg_i.uniform_sector_select)) begin
							op_quad_reg  <= dec_quad;
							op_erase_reg <= dec_erase;
							// a 3-byte address must not inherit a stale top byte
							addr_reg     <= `FPS_RST_ADDR;
							lst_reg      <= L_ADDR;
						end else begin
							lst_reg <= L_SKIP;
						end
					end
				end
				L_ADDR: begin
					if (byte_ev) begin
						addr_reg     <= {addr_reg[23:0], byte_new};
						addr_cnt_reg <= 2'(addr_cnt_reg + 2'h1);
						if (addr_cnt_reg == addr_last_reg) begin
							lst_reg      <= op_erase_reg ? L_ARMED : L_DATA;
							got_data_reg <= 1'b0;
							wr_off_reg   <= {addr_reg[0], byte_new} & pg_last;
						end
					end
				end
				L_DATA: begin
					if (byte_ev) begin
						got_data_reg <= 1'b1;
						wr_off_reg   <= 9'(wr_off_reg + 9'h001) & pg_last;
					end
				end
				L_ARMED: begin
					lst_reg <= L_SKIP;
				end
				L_SKIP: begin
					lst_reg <= L_SKIP;
				end
				default: begin
					lst_reg <= L_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// page buffer and loaded-byte mask
	// ----------------------------------------
	logic         data_we;
	logic         enter_data;
	logic [511:0] vld_reg;
	logic [8:0]   rd_idx_reg;
	logic [7:0]   rd_data;

	assign data_we    = lst_reg == L_DATA && byte_ev;
	assign enter_data = lst_reg == L_ADDR && byte_ev && addr_cnt_reg == addr_last_reg
		&& !op_erase_reg;

	fps_page_buf #(
		.DEPTH   (512),
		.AW      (9),
		.DW      (8)
	) u_buf (
		.clk_i   (clk_sys_i),
		.we_i    (data_we),
		.waddr_i (wr_off_reg),
		.wdata_i (byte_new),
		.raddr_i (rd_idx_reg),
		.rdata_o (rd_data)
	);

	// only loaded bytes reach the array; the rest of the page is left alone
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			vld_reg <= '0;
		end else if (enter_data) begin
			vld_reg <= '0;
		end else if (data_we) begin
			vld_reg[wr_off_reg] <= 1'b1;
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wel_reg <= 1'b0;
		end else if (write_enable_command_done) begin
			wel_reg <= 1'b1;
		end else if (wel_clr) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wip_reg <= 1'b0;
		end else if (go_prog || go_erase) begin
			wip_reg <= 1'b1;
		end else if (eng_done) begin
			wip_reg <= 1'b0;
		end
	end

	// a flag raised in the clearing cycle survives the clear
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			perr_reg <= 1'b0;
			eerr_reg <= 1'b0;
		end else begin
			perr_reg <= set_perr || (perr_reg && !clr_err_i);
			eerr_reg <= set_eerr || (eerr_reg && !clr_err_i);
		end
	end

	assign status_o = '{write_in_progress: wip_reg, write_enable_latch: wel_reg,
		program_fail_bit: perr_reg, erase_fail_bit: eerr_reg};

	// ----------------------------------------
	// array engine
	// ----------------------------------------
	fps_arr_t     arr_reg;
	logic [1:0]   ph_reg;
	logic [31:0]  base_reg;
	logic [8:0]   last_reg;

	// three cycles per byte: address out, data and unit state, write strobe
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			eng_reg    <= E_IDLE;
			arr_reg    <= '0;
			ph_reg     <= 2'h0;
			rd_idx_reg <= 9'h000;
			base_reg   <= `FPS_RST_ADDR;
			last_reg   <= 9'h000;
		end else begin
			arr_reg.wr     <= 1'b0;
			arr_reg.erase  <= 1'b0;
			arr_reg.commit <= 1'b0;
			unique case (eng_reg)
				E_IDLE: begin
					if (go_prog) begin
						base_reg   <= addr_reg & ~{23'h00_0000, pg_last};
						last_reg   <= pg_last;
						rd_idx_reg <= 9'h000;
						ph_reg     <= 2'h0;
						eng_reg    <= E_PROG;
					end else if (go_erase) begin
						arr_reg.erase <= 1'b1;
						arr_reg.addr  <= addr_reg;
						eng_reg       <= E_WAIT;
					end
				end
				E_PROG: begin
					if (ph_reg == 2'h0) begin
						arr_reg.addr <= {base_reg[31:9], base_reg[8:0] | rd_idx_reg};
						ph_reg       <= 2'h1;
					end else if (ph_reg == 2'h1) begin
						arr_reg.data    <= rd_data;
						arr_reg.ecc_dis <= arr_unit_used_i;
						ph_reg          <= 2'h2;
					end else begin
						arr_reg.wr <= vld_reg[rd_idx_reg];
						ph_reg     <= 2'h0;
						if (rd_idx_reg == last_reg) begin
							arr_reg.commit <= 1'b1;
							eng_reg        <= E_WAIT;
						end else begin
							rd_idx_reg <= 9'(rd_idx_reg + 9'h001);
						end
					end
				end
				E_WAIT: begin
					if (arr_done_i) begin
						eng_reg <= E_IDLE;
					end
				end
				default: begin
					eng_reg <= E_IDLE;
				end
			endcase
		end
	end
	assign arr_o = arr_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	AST_LAUNCH_NEEDS_LATCH: assert property ((go_prog || go_erase) |-> wel_reg)
		else $error("operation launched without write enable latch");
	AST_LAUNCH_SETS_BUSY: assert property ((go_prog || go_erase) |=> wip_reg ##1 wip_reg)
		else $error("busy flag not raised on launch");
	AST_DONE_CLEARS: assert property (eng_done |=> !wip_reg && !wel_reg)
		else $error("busy or latch left set after completion");
	AST_QUAD_NEEDS_EN: assert property (at_open && dec_quad && !cfg_i.quad_enable
		|=> lst_reg == L_SKIP)
		else $error("four-line program taken without quad enable");
	AST_UNIFORM_IGNORE: assert property (at_open && dec_erase
		&& cfg_i.uniform_sector_select |=> lst_reg == L_SKIP && $stable(wel_reg))
		else $error("parameter erase not ignored in uniform mode");
	AST_BUSY_REJECT: assert property (at_open && (dec_prog || dec_erase) && wip_reg
		|=> lst_reg != L_ADDR)
		else $error("command taken while busy");
	AST_PAGE_WRAP: assert property (data_we && wr_off_reg == pg_last
		|=> wr_off_reg == 9'h000)
		else $error("load offset did not wrap to page start");
	AST_EXTRA_EDGE_DROP: assert property (lst_reg == L_ARMED && sel && sck_rise
		|=> lst_reg == L_SKIP ##1 !go_erase)
		else $error("erase kept after extra clock");
	AST_LARGE_SECT: assert property (erase_end && !in_param
		|=> !wip_reg && $stable(eerr_reg))
		else $error("erase outside parameter region acted");
	AST_PROT_ERASE: assert property (erase_end && in_param && hit_prot
		|=> eerr_reg && !wip_reg)
		else $error("protected erase not flagged");

	COV_PROG: cover property (go_prog ##[1:1000] eng_done);
	COV_ERASE: cover property (go_erase);
	COV_WRAP: cover property (data_we && wr_off_reg == pg_last);
	COV_EERR: cover property (set_eerr);

endmodule

/* File: dv/fps_host.sv */
`timescale 1ns/1ps
module fps_host (
	// clock
	input  wire logic  clk_i,
	// serial link
	output logic       sck_o,
	output logic       cs_n_o,
	output logic [3:0] io_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
	end
	// released lines toggle so no stale level survives
	always @(posedge clk_i) begin
		if (cs_n_o) begin
			io_o <= ~io_o;
		end
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bit_out(input logic [3:0] v);
		io_o <= v;
		tk(4);
		sck_o <= 1'b1;
		tk(4);
		sck_o <= 1'b0;
	endtask
	task automatic send(input logic [7:0] b, input logic q);
		if (q) begin
			bit_out(b[7:4]);
			bit_out(b[3:0]);
		end else begin
			for (int i = 7; i >= 0; i--) begin
				bit_out({~io_o[3:1], b[i]});
			end
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input logic q);
		cs_n_o <= 1'b0;
		tk(1);
		send(op, q);
		for (int i = na - 1; i >= 0; i--) begin
			send(a[8*i+:8], q);
		end
	endtask
	task automatic stop();
		tk(4);
		cs_n_o <= 1'b1;
		tk(4);
	endtask
endmodule

/* File: dv/fps_top_test.sv */
`timescale 1ns/1ps
`include "fps_map.svh"
`define CHK(nm, ex, gt) \
	begin \
		checks_done++; \
		if ((gt) !== (ex)) begin \
			miscompares++; \
			$display("unexpected %s exp %0h got %0h", nm, ex, gt); \
		end \
	end
module fps_top_test;
	import fps_pkg::*;
	logic        clk, rst_n, clr, used, done, fail, eccd, sck, cs_n;
	logic [3:0]  io, io_o, io_oe;
	logic [31:0] era;
	logic [7:0]  mem [logic [31:0]];
	fps_cfg_t    cfg;
	fps_prot_t   prot;
	fps_status_t st;
	fps_arr_t    arr;
	int          nwr, nera, dly, cnt, checks_done, miscompares;
	// erase cases: mode {extra edge, four lane, uniform, top}, prot {bp, sector}
	localparam logic [31:0] ea [8] = '{32'h1000, 32'h7F_9000, 32'h1000, 32'h1_0000,
		32'h2000, 32'h4000, 32'h3000, 32'h5000};
	localparam logic [3:0] em [8] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8};
	localparam logic [1:0] ep [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
	// expected {erased, erase error, latch check 2 = skip}
	localparam logic [3:0] ex [8] = '{4'h8, 4'h8, 4'h1, 4'h0, 4'h4, 4'h4, 4'h8, 4'h2};
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	fps_top dut (
		.clk_sys_i      (clk),
		.reset_n_i      (rst_n),
		.sck_i          (sck),
		.cs_n_i         (cs_n),
		.io_i           (io),
		.io_o           (io_o),
		.io_oe_o        (io_oe),
		.cfg_i          (cfg),
		.prot_i         (prot),
		.clr_err_i      (clr),
		.status_o       (st),
		.arr_o          (arr),
		.arr_unit_used_i(used),
		.arr_done_i     (done),
		.arr_fail_i     (fail)
	);
	fps_host h (
		.clk_i (clk),
		.sck_o (sck),
		.cs_n_o(cs_n),
		.io_o  (io)
	);
	// ----------------------------------------
	// array stand-in
	// ----------------------------------------
	always @(posedge clk) begin
		done <= (cnt == 1);
		if (arr.wr) begin
			mem[arr.addr] = arr.data;
			nwr++;
			eccd = arr.ecc_dis;
		end
		if (arr.erase) begin
			nera++;
			era = arr.addr;
		end
		if (arr.commit || arr.erase) begin
			cnt <= dly;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	// ----------------------------------------
	// helpers and scenarios
	// ----------------------------------------
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic idle();
		int k;
		k = 0;
		while (st.write_in_progress !== 1'b0 && k < 5000) begin
			tk(1);
			k++;
		end
		`CHK("idle", 1'b1, k < 5000)
	endtask
	task automatic clear();
		clr <= 1'b1;
		tk(1);
		clr <= 1'b0;
		tk(2);
	endtask
	task automatic write_enable_command(input logic q);
		h.cmd(`FPS_OPC_WR_ENABLE, 32'h0, 0, q);
		h.stop();
		tk(8);
	endtask
	task automatic prog(input logic we, input logic [7:0] op, input logic [31:0] a,
		input int na, input int n);
		logic ql, qd;
		tk(1);
		ql = cfg.four_lane_command_mode;
		qd = ql || op == `FPS_OPC_QUAD_PROG || op == `FPS_OPC_QUAD_PROG_4B;
		mem.delete();
		nwr = 0;
		if (we) write_enable_command(ql);
		h.cmd(op, a, na, ql);
		for (int i = 0; i < n; i++) begin
			h.send(8'hA0 + 8'(i), qd);
		end
		h.stop();
		tk(8);
	endtask
	task automatic t_wrap();
		write_enable_command(1'b0);
		`CHK("wel", 1'b1, st.write_enable_latch)
		prog(1'b0, `FPS_OPC_PAGE_PROG, 32'h0000_01FE, 3, 4);
		`CHK("wip", 1'b1, st.write_in_progress)
		idle();
		`CHK("nwr", 4, nwr)
		`CHK("wrap", 8'hA2, mem[32'h0000_0100])
		`CHK("last", 8'hA1, mem[32'h0000_01FF])
		`CHK("wel", 1'b0, st.write_enable_latch)
		`CHK("ecc", 1'b0, eccd)
		prog(1'b0, `FPS_OPC_PAGE_PROG, 32'h0000_0200, 3, 1);
		idle();
		`CHK("nowel", 0, nwr)
	endtask
	task automatic t_big();
		cfg.page_size_select <= 1'b1;
		prog(1'b1, `FPS_OPC_PAGE_PROG_4B, 32'h0000_03FF, 4, 2);
		idle();
		`CHK("p512", 8'hA1, mem[32'h0000_0200])
		cfg.address_length_select <= 1'b1;
		prog(1'b1, `FPS_OPC_PAGE_PROG, 32'h0012_3456, 4, 1);
		idle();
		`CHK("a4", 8'hA0, mem[32'h0012_3456])
		cfg <= '0;
	endtask
	task automatic t_quad();
		prog(1'b1, `FPS_OPC_QUAD_PROG, 32'h0000_0400, 3, 1);
		idle();
		`CHK("noquad", 0, nwr)
		`CHK("qwel", 1'b0, st.write_enable_latch)
		cfg.quad_enable <= 1'b1;
		prog(1'b1, `FPS_OPC_QUAD_PROG, 32'h0000_0400, 3, 16);
		idle();
		`CHK("q16", 16, nwr)
		`CHK("qlast", 8'hAF, mem[32'h0000_040F])
		prog(1'b1, `FPS_OPC_QUAD_PROG_4B, 32'h0000_0500, 4, 1);
		idle();
		`CHK("q34", 8'hA0, mem[32'h0000_0500])
		cfg.alt_address_length_bit <= 1'b1;
		cfg.four_lane_command_mode <= 1'b1;
		prog(1'b1, `FPS_OPC_QUAD_PROG, 32'h0001_0010, 4, 1);
		idle();
		`CHK("q4", 8'hA0, mem[32'h0001_0010])
		`CHK("iodrv", 8'h00, {io_oe, io_o})
		cfg <= '0;
	endtask
	task automatic t_fail();
		used <= 1'b1;
		fail <= 1'b1;
		prog(1'b1, `FPS_OPC_PAGE_PROG, 32'h0000_0600, 3, 1);
		idle();
		`CHK("eccd", 1'b1, eccd)
		`CHK("pfail", 1'b1, st.program_fail_bit)
		used <= 1'b0;
		fail <= 1'b0;
		clear();
		prot.bp_en <= 1'b1;
		prog(1'b1, `FPS_OPC_PAGE_PROG, 32'h0000_4100, 3, 1);
		idle();
		`CHK("pprot", 1'b1, st.program_fail_bit)
		`CHK("pnwr", 0, nwr)
		prot.bp_en <= 1'b0;
		clear();
	endtask
	task automatic t_erase();
		for (int i = 0; i < 8; i++) begin
			cfg.uniform_sector_select <= em[i][1];
			cfg.param_top <= em[i][0];
			cfg.four_lane_command_mode <= em[i][2];
			cfg.address_length_select <= em[i][2];
			prot.per_sector_protection <= {5'h0, ep[i][0], 2'h0};
			prot.bp_en <= ep[i][1];
			nera = 0;
			write_enable_command(em[i][2]);
			h.cmd(em[i][0] ? 8'h21 : 8'h20, ea[i], (em[i][0] || em[i][2]) ? 4 : 3, em[i][2]);
			if (em[i][3]) h.bit_out(4'h0);
			h.stop();
			tk(8);
			`CHK("ewip", ex[i][3], st.write_in_progress)
			idle();
			`CHK("erase", ex[i][3], nera == 1)
			if (ex[i][3]) `CHK("eaddr", ea[i], era)
			`CHK("efail", ex[i][2], st.erase_fail_bit)
			if (ex[i][1:0] != 2'h2) `CHK("ewel", ex[i][0], st.write_enable_latch)
			clear();
		end
		cfg <= '0;
		prot.per_sector_protection <= '0;
		prot.bp_en <= 1'b0;
	endtask
	task automatic t_busy();
		dly = 3000;
		write_enable_command(1'b0);
		h.cmd(`FPS_OPC_PARAM_ERASE, 32'h1000, 3, 1'b0);
		h.stop();
		tk(8);
		write_enable_command(1'b0);
		`CHK("bwel", 1'b0, st.write_enable_latch)
		prog(1'b0, `FPS_OPC_PAGE_PROG, 32'h0000_0700, 3, 1);
		idle();
		`CHK("bnwr", 0, nwr)
		dly = 20;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		clr = 1'b0;
		used = 1'b0;
		done = 1'b0;
		fail = 1'b0;
		cfg = '0;
		prot = '{1'b0, 32'h0000_4000, 32'h0000_4FFF, 8'h00};
		nwr = 0;
		nera = 0;
		dly = 20;
		cnt = 0;
		checks_done = 0;
		miscompares = 0;
		tk(12);
		rst_n <= 1'b1;
		tk(8);
		t_wrap();
		t_big();
		t_quad();
		t_fail();
		t_erase();
		t_busy();
		end_sim();
	end
	// hang guard, well past the longest expected run
	initial begin
		tk(80000);
		miscompares++;
		end_sim();
	end
endmodule
